/* File: rtl/ewsc_top.sv */
// External area wait-state controller with AHB-Lite register slave
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
// Notes on behaviour
// - Each area is 128 kbytes in 1-Mbyte space, 2 Mbytes in 16-Mbyte space.
// - Eight equal areas 0..7 in ascending address order from zero.
// - Three-state bit 0: access in exactly 2 states, never any waits.
// - Three-state bit 1: 3 base states plus waits from the wait mode.
// - Enable 0 gives pin mode 0; else field picks prog, none, pin 1, auto.
// - Each area has its own three-state bit and wait-enable bit.
// - One shared two-bit wait-mode field for all areas.
// - Bus spec comes only from per-area bits and the shared wait-mode and wait-count fields.
// - External space above on-chip RAM follows area 7 settings.
// - Two-bit wait count; programmable mode inserts exactly that many.
// - Pin mode 0 waits while wait input low at T2 falling edge.
// - Pin mode 1 inserts count, then waits while input low; count 0 = mode 0.
// - Auto mode inserts count if input low in T2, nothing more.
module ewsc_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ext_req,
	input wire logic [23:0] ext_addr,
	input wire logic ext_wait_n,
	output logic ext_busy,
	output logic ext_done,
	output logic [2:0] ext_area,
	output logic ext_t3,
	output logic ext_tw
);
	// =====================================================
	// Register slave
	logic [7:0] access_state_control_reg;
	logic [7:0] wait_controller_enable_reg;
	logic [3:0] wait_control_reg;
	logic addr_16m;
	logic wr_pend;
	logic [7:0] wr_ofs;
	logic [2:0] last_area;

	function automatic logic [31:0] ewsc_read(input logic [7:0] ofs);
		case (ofs)
			ewsc_pkg::OFS_ACCESS_STATE: ewsc_read = {24'h000000, access_state_control_reg};
			ewsc_pkg::OFS_WAIT_ENABLE: ewsc_read = {24'h000000, wait_controller_enable_reg};
			ewsc_pkg::OFS_WAIT_CONTROL: ewsc_read = {24'h000000, ewsc_pkg::WCR_RSVD_ONES,
				wait_control_reg};
			ewsc_pkg::OFS_MODE_CONTROL: ewsc_read = {31'h00000000, addr_16m};
			ewsc_pkg::OFS_STATUS: ewsc_read = {27'h0000000, ext_busy, ext_tw, last_area};
			default: ewsc_read = 32'h00000000;
		endcase
	endfunction : ewsc_read

	wire logic addr_ok = hsel && hready && htrans == ewsc_pkg::HTRANS_NONSEQ;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_ofs <= 8'h00;
		end else begin
			wr_pend <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_ofs <= haddr[7:0];
			end
		end
	end

	// Read data is sampled in the address phase so it lands in the data phase
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_ok && !hwrite) begin
				hrdata <= ewsc_read(haddr[7:0]);
			end
		end
	end

	// Settings written mid-access take effect from the next access
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			access_state_control_reg <= ewsc_pkg::RST_ACCESS_STATE;
			wait_controller_enable_reg <= ewsc_pkg::RST_WAIT_ENABLE;
			wait_control_reg <= ewsc_pkg::RST_WAIT_CONTROL;
			addr_16m <= 1'b0;
		end else if (wr_pend) begin
			case (wr_ofs)
				ewsc_pkg::OFS_ACCESS_STATE: access_state_control_reg <= hwdata[7:0];
				ewsc_pkg::OFS_WAIT_ENABLE: wait_controller_enable_reg <= hwdata[7:0];
				ewsc_pkg::OFS_WAIT_CONTROL: wait_control_reg <= hwdata[3:0];
				ewsc_pkg::OFS_MODE_CONTROL: addr_16m <= hwdata[0];
				default: ;
			endcase
		end
	end

	// =====================================================
	// Area decode and wait mode
	function automatic logic [2:0] ewsc_area(input logic [23:0] a, input logic m16);
		// Top of map above on-chip RAM falls in area 7 by this decode
		ewsc_area = m16 ? a[ewsc_pkg::AREA_LSB_16M +: 3] :
			a[ewsc_pkg::AREA_LSB_1M +: 3];
	endfunction : ewsc_area

	function automatic ewsc_pkg::ewsc_wmode_t ewsc_mode(input logic ast, input logic wce,
		input logic [1:0] wms);
		if (!ast) begin
			ewsc_mode = ewsc_pkg::EWSC_WM_NONE;
		end else if (!wce) begin
			ewsc_mode = ewsc_pkg::EWSC_WM_PIN0;
		end else begin
			case (wms)
				ewsc_pkg::WMS_PROG: ewsc_mode = ewsc_pkg::EWSC_WM_PROG;
				ewsc_pkg::WMS_NONE: ewsc_mode = ewsc_pkg::EWSC_WM_NONE;
				ewsc_pkg::WMS_PIN1: ewsc_mode = ewsc_pkg::EWSC_WM_PIN1;
				default: ewsc_mode = ewsc_pkg::EWSC_WM_AUTO;
			endcase
		end
	endfunction : ewsc_mode

	// =====================================================
	// Access sequencer
	typedef enum {EWSC_IDLE, EWSC_T1, EWSC_T2, EWSC_TW, EWSC_T3} ewsc_state_t;
	ewsc_state_t state;
	ewsc_pkg::ewsc_wmode_t mode;
	logic three_state;
	logic [1:0] wait_left;
	logic pin_phase;
	// Count latched at take, so a write mid-access cannot change it
	logic [1:0] wcount;

	// Wait input taken as synchronous; falling-edge sampling is modelled at the state edge
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= EWSC_IDLE;
			mode <= ewsc_pkg::EWSC_WM_NONE;
			three_state <= 1'b0;
			wait_left <= 2'h0;
			wcount <= 2'h0;
			pin_phase <= 1'b0;
			last_area <= 3'h0;
			ext_busy <= 1'b0;
			ext_done <= 1'b0;
			ext_area <= 3'h0;
			ext_t3 <= 1'b0;
			ext_tw <= 1'b0;
		end else begin
			ext_done <= 1'b0;
			case (state)
				EWSC_IDLE: begin
					if (ext_req) begin
						last_area <= ewsc_area(ext_addr, addr_16m);
						ext_area <= ewsc_area(ext_addr, addr_16m);
						three_state <= access_state_control_reg[ewsc_area(ext_addr, addr_16m)];
						mode <= ewsc_mode(access_state_control_reg[ewsc_area(ext_addr, addr_16m)],
							wait_controller_enable_reg[ewsc_area(ext_addr, addr_16m)],
							wait_control_reg[ewsc_pkg::WMODE_LSB +: 2]);
						ext_t3 <= access_state_control_reg[ewsc_area(ext_addr, addr_16m)];
						wcount <= wait_control_reg[ewsc_pkg::WCOUNT_LSB +: 2];
						ext_busy <= 1'b1;
						state <= EWSC_T1;
					end
				end
				EWSC_T1: state <= EWSC_T2;
				EWSC_T2: begin
					pin_phase <= 1'b0;
					wait_left <= wcount;
					if (!three_state) begin
						ext_busy <= 1'b0;
						ext_done <= 1'b1;
						state <= EWSC_IDLE;
					end else begin
						case (mode)
							ewsc_pkg::EWSC_WM_PROG: state <= (wcount != 2'h0) ? EWSC_TW : EWSC_T3;
							ewsc_pkg::EWSC_WM_PIN0: begin
								pin_phase <= 1'b1;
								state <= !ext_wait_n ? EWSC_TW : EWSC_T3;
							end
							ewsc_pkg::EWSC_WM_PIN1: begin
								pin_phase <= (wcount == 2'h0);
								state <= (wcount != 2'h0 || !ext_wait_n) ? EWSC_TW : EWSC_T3;
							end
							ewsc_pkg::EWSC_WM_AUTO: state <= (!ext_wait_n && wcount != 2'h0) ?
								EWSC_TW : EWSC_T3;
							default: state <= EWSC_T3;
						endcase
						ext_tw <= (mode == ewsc_pkg::EWSC_WM_PROG && wcount != 2'h0) ||
							(mode == ewsc_pkg::EWSC_WM_PIN0 && !ext_wait_n) ||
							(mode == ewsc_pkg::EWSC_WM_PIN1 && (wcount != 2'h0 || !ext_wait_n)) ||
							(mode == ewsc_pkg::EWSC_WM_AUTO && !ext_wait_n && wcount != 2'h0);
					end
				end
				EWSC_TW: begin
					if (pin_phase) begin
						if (ext_wait_n) begin
							state <= EWSC_T3;
							ext_tw <= 1'b0;
						end
					end else if (wait_left > 2'h1) begin
						wait_left <= wait_left - 2'h1;
					end else if (mode == ewsc_pkg::EWSC_WM_PIN1 && !ext_wait_n) begin
						pin_phase <= 1'b1;
					end else begin
						state <= EWSC_T3;
						ext_tw <= 1'b0;
					end
				end
				EWSC_T3: begin
					ext_busy <= 1'b0;
					ext_done <= 1'b1;
					ext_t3 <= 1'b0;
					state <= EWSC_IDLE;
				end
				default: state <= EWSC_IDLE;
			endcase
		end
	end
endmodule : ewsc_top

/* File: inc/ewsc_pkg.sv */
// Package: register map, field layout, reset values and modes of the wait-state controller
package ewsc_pkg;
	localparam logic [7:0] OFS_ACCESS_STATE = 8'h00;
	localparam logic [7:0] OFS_WAIT_ENABLE = 8'h04;
	localparam logic [7:0] OFS_WAIT_CONTROL = 8'h08;
	localparam logic [7:0] OFS_MODE_CONTROL = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] RST_ACCESS_STATE = 8'hFF;
	localparam logic [7:0] RST_WAIT_ENABLE = 8'hFF;
	localparam logic [3:0] RST_WAIT_CONTROL = 4'h3;
	localparam logic [3:0] WCR_RSVD_ONES = 4'hF;
	localparam int WMODE_LSB = 2;
	localparam int WCOUNT_LSB = 0;
	localparam int AREA_COUNT = 8;
	localparam int ADDR_W = 24;
	localparam int AREA_LSB_1M = 17;
	localparam int AREA_LSB_16M = 21;
	localparam logic [1:0] WMS_PROG = 2'h0;
	localparam logic [1:0] WMS_NONE = 2'h1;
	localparam logic [1:0] WMS_PIN1 = 2'h2;
	localparam logic [1:0] WMS_AUTO = 2'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [2:0] {
		EWSC_WM_NONE,
		EWSC_WM_PIN0,
		EWSC_WM_PROG,
		EWSC_WM_PIN1,
		EWSC_WM_AUTO
	} ewsc_wmode_t;
endpackage : ewsc_pkg

/* File: test/ewsc_properties.sv */
// Checker: external access timing and bus answer of the wait-state controller
`timescale 1ns/10ps
module ewsc_properties (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic ext_req,
	input wire logic ext_busy,
	input wire logic ext_done,
	input wire logic ext_t3,
	input wire logic ext_tw
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_start3;
		$rose(ext_busy) && ext_t3;
	endsequence
	sequence s_two_end;
		ext_busy && !ext_tw ##1 ext_done && !ext_busy;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled");
	a_req_taken: assert property (!ext_busy && ext_req |=> ext_busy) else $error("req lost");
	a_two_state: assert property ($rose(ext_busy) && !ext_t3 |=> s_two_end)
		else $error("two-state length");
	a_three_base: assert property (s_start3 |=> ext_busy [*2]) else $error("short");
	a_three_end: assert property (s_start3 |-> ##[3:40] ext_done) else $error("hang");
	a_wait_t3: assert property (ext_tw |-> ext_t3 && ext_busy) else $error("stray wait");
	a_wait_end: assert property ($fell(ext_tw) |-> ext_busy ##1 ext_done)
		else $error("no last state");
	a_done_once: assert property (ext_done |-> !ext_busy ##1 !ext_done) else $error("done");
endmodule : ewsc_properties
bind ewsc_top ewsc_properties u_props (.sys_clk, .rst_n, .hreadyout, .hresp, .ext_req,
	.ext_busy, .ext_done, .ext_t3, .ext_tw);

/* File: test/ewsc_ext_model.sv */
// Partner: external device that holds the wait input low from the second state
`timescale 1ns/10ps
module ewsc_ext_model (
	input wire logic sys_clk,
	input wire logic ext_busy,
	input wire logic [3:0] hold_len,
	output logic ext_wait_n
);
	logic [3:0] cyc;
	always_ff @(posedge sys_clk) begin
		cyc <= ext_busy ? cyc + 4'h1 : 4'h0;
	end
	// Pulled-up line, so high whenever the device lets go
	assign ext_wait_n = !(ext_busy && cyc != 4'h0 && cyc <= hold_len);
endmodule : ewsc_ext_model

/* File: test/testbench.sv */
// Testbench: register and wait-mode scenarios of the wait-state controller
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
	$display("BAD %0t %h %h", $time, a, e); end end
module testbench;
	logic sys_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, ext_req = 1'b0;
	logic hreadyout, hresp, ext_wait_n, ext_busy, ext_done, ext_t3, ext_tw;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [23:0] ext_addr = 24'h0;
	logic [3:0] hold_len = 4'h0;
	logic [2:0] ext_area;
	logic [1:0] htrans = 2'h0;
	int n_fail = 0, n_compared = 0, n;
	ewsc_top DUT (.sys_clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_req, .ext_addr, .ext_wait_n,
		.ext_busy, .ext_done, .ext_area, .ext_t3, .ext_tw);
	ewsc_ext_model u_ext (.sys_clk, .ext_busy, .hold_len, .ext_wait_n);
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic bus(input logic [7:0] a, d, input logic w);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	// Config word: three-state bits, wait enables, wait control, 16-Mbyte flag
	task automatic acc(input logic [31:0] c, input logic [2:0] ar, input logic [3:0] h, int len);
		int nw;
		int nt;
		nw = 0;
		nt = 0;
		for (int i = 0; i < 4; i++)
			bus(8'(4 * i), c[31 - 8 * i -: 8], 1'b1);
		hold_len <= h;
		ext_addr <= c[0] ? {ar, 21'h1FF000} : {4'h0, ar, 17'h1F000};
		ext_req <= 1'b1;
		@(posedge sys_clk);
		ext_req <= 1'b0;
		n = 0;
		repeat (40) begin
			@(posedge sys_clk);
			if (ext_done === 1'b1) break;
			if (ext_busy === 1'b1) n++;
			if (ext_tw === 1'b1) nw++;
			if (ext_t3 === 1'b1) nt++;
		end
		`CHK(n, len)
		`CHK(nt, (len == 2) ? 0 : len)
		`CHK(nw, (len > 3) ? len - 3 : 0)
		`CHK(ext_area, ar)
		bus(8'h10, 8'h0, 1'b0);
		`CHK(rd[4:0], 5'(ar))
	endtask : acc
	task automatic check_reset_values();
		bus(8'h00, 8'h0, 1'b0);
		`CHK(rd[7:0], 8'hFF)
		bus(8'h04, 8'h0, 1'b0);
		`CHK(rd[7:0], 8'hFF)
		bus(8'h0C, 8'h0, 1'b0);
		`CHK(rd, 32'h0)
		bus(8'h10, 8'h0, 1'b0);
		`CHK(rd, 32'h0)
		bus(8'h08, 8'h0, 1'b0);
		`CHK(rd[7:0], 8'hF3)
		bus(8'h14, 8'h0, 1'b0);
		`CHK(rd, 32'h0)
	endtask : check_reset_values
	task automatic check_wait_modes();
		acc(32'hFFFFF300, 3'h0, 4'h0, 6);
		acc(32'hF7FF0300, 3'h3, 4'h3, 2);
		acc(32'hFFFE0000, 3'h0, 4'h2, 5);
		acc(32'hFFFF0200, 3'h1, 4'h0, 5);
		acc(32'hFFFF0700, 3'h2, 4'h3, 3);
		acc(32'hFFFF0900, 3'h4, 4'h3, 6);
		acc(32'hFFFF0800, 3'h5, 4'h2, 5);
		acc(32'hFFFF0E00, 3'h7, 4'h5, 5);
		acc(32'hFFFF0E00, 3'h7, 4'h0, 3);
		acc(32'hFFFF0001, 3'h3, 4'h0, 3);
	endtask : check_wait_modes
	task automatic finish_test();
		$display("%0d of %0d compares failed", n_fail, n_compared);
		if (n_fail == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		check_reset_values();
		check_wait_modes();
		finish_test();
	end
	// Run needs under a thousand cycles; 20000 leaves ample margin
	initial begin
		#500000;
		n_fail++;
		finish_test();
	end
endmodule : testbench
